// ==== dtt_pkg.sv ====
// Functional notes
// - Eight-bit up-counter, 128 Hz down to 1 Hz
// - Low nibble, then high nibble at next address
// - Low read freezes high carries until released
// - High read first arms no hold
// - Tap falling edge sets flag, may interrupt
// - Flags set regardless of enable bits
// - Four enable bits, one enables, reset zero
// - Four flags, write one clears, reset zero
// - Count nibbles are read-only
// - Reset clears all counter bits
// - Clear strobe zeroes counter, run bit taken from the same write
// - Clear bit and upper bits read zero
// - Run bit starts and stops, reset zero
// - Stopped counter keeps its value
package dtt_pkg;

  ////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  // 256 Hz counter input period
  localparam int unsigned TICK_PERIOD_NS = 3906250;
  localparam int unsigned TICK_DIV       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // High nibble hold window; the least time is used
  localparam int unsigned HOLD_MIN_NS    = 480000;
  localparam int unsigned HOLD_MAX_NS    = 1500000;
  localparam int unsigned HOLD_CYC       =
    (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////
  // Types
  typedef logic [19:0] dtt_pre_t;   // Prescaler count
  typedef logic [15:0] dtt_hold_t;  // Hold window count
  typedef logic [15:0] dtt_addr_t;  // I/O address
  typedef logic [3:0]  dtt_nib_t;   // One data nibble

  ////////////////////////////////////////////////////////////////
  // Register map
  localparam dtt_addr_t ADDR_CTL  = 16'hFF78;  // tick_control
  localparam dtt_addr_t ADDR_LOW  = 16'hFF79;  // tick_count_low
  localparam dtt_addr_t ADDR_HIGH = 16'hFF7A;  // tick_count_high
  localparam dtt_addr_t ADDR_EN   = 16'hFFE6;  // tick_irq_enable
  localparam dtt_addr_t ADDR_FLAG = 16'hFFF6;  // tick_irq_flags

  // Control fields
  localparam int unsigned CTL_RUN_BIT = 0;  // count_run_ctl
  localparam int unsigned CTL_CLR_BIT = 1;  // count_clear_strobe

  // Counter bits feeding the four taps (32, 8, 2, 1 Hz)
  localparam int unsigned TAP_N = 4;
  localparam int unsigned TAP_POS [TAP_N] = '{2, 4, 6, 7};
  localparam dtt_nib_t    NIB_MAX = 4'hF;
  localparam dtt_nib_t    NIB_ONE = 4'h1;

  ////////////////////////////////////////////////////////////////
  // Register port request
  typedef struct packed {
    dtt_addr_t addr;    // Byte address
    dtt_nib_t  wrData;  // Write nibble
    logic      wrEn;    // Write strobe
    logic      rdEn;    // Read strobe
  } dtt_bus_req_s;

  // Whole block state
  typedef struct packed {
    dtt_pre_t  preCnt;     // 256 Hz prescaler
    dtt_nib_t  cntLow;     // 128..16 Hz bits
    dtt_nib_t  cntHigh;    // 8..1 Hz bits
    logic      runCtl;     // count_run_ctl
    logic      holdOn;     // High nibble frozen
    dtt_hold_t holdCnt;    // Cycles spent frozen
    logic      carryWait;  // Carry deferred by hold
    dtt_nib_t  tapPrev;    // Taps one cycle ago
    dtt_nib_t  irqFlag;    // irq_flag_32hz..1hz
    dtt_nib_t  irqEnable;  // irq_enable_32hz..1hz
    dtt_nib_t  rdData;     // Read answer
    logic      irq;        // Interrupt level
  } dtt_state_s;

  localparam dtt_state_s STATE_RST = '0;

endpackage : dtt_pkg

// ==== dtt_tick_timer.sv ====
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module dtt_tick_timer #(
  parameter dtt_pkg::dtt_pre_t  TICK_DIV =
    dtt_pkg::dtt_pre_t'(dtt_pkg::TICK_DIV),
  parameter dtt_pkg::dtt_hold_t HOLD_CYC =
    dtt_pkg::dtt_hold_t'(dtt_pkg::HOLD_CYC)
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Register port
  input  dtt_pkg::dtt_bus_req_s busReq,
  output dtt_pkg::dtt_nib_t     busRdData,
  // Interrupt
  output logic                  tickIrq
);

  ////////////////////////////////////////////////////////////////
  // Declarations
  // Strobes below are decoded from the request in the same cycle;
  // only state_ff carries memory from one edge to the next
  dtt_pkg::dtt_state_s state_ff;   // Registered state
  dtt_pkg::dtt_state_s nxt_state;  // Next state
  logic [7:0]          cntAll;     // tick_count_bits
  dtt_pkg::dtt_nib_t   tapNow;     // Tap levels now
  dtt_pkg::dtt_nib_t   tapFall;    // Tap falling edges
  logic                tick;       // 256 Hz enable
  logic                carry;      // Low nibble wraps
  logic                release_;   // Hold ends
  logic                rdLow;      // Low nibble read
  logic                rdHigh;     // High nibble read
  logic                wrCtl;      // Control write
  logic                wrEn;       // Enable write
  logic                wrFlag;     // Flag write
  logic                doClear;    // Clear strobe

  // Outputs come straight from the state flops
  assign busRdData = state_ff.rdData;
  assign tickIrq   = state_ff.irq;

  ////////////////////////////////////////////////////////////////
  // Address decode; data nibbles have no write decode at all
  // A write to an unmapped address decodes to nothing and is lost
  assign rdLow   = busReq.rdEn && busReq.addr == dtt_pkg::ADDR_LOW;
  assign rdHigh  = busReq.rdEn && busReq.addr == dtt_pkg::ADDR_HIGH;
  assign wrCtl   = busReq.wrEn && busReq.addr == dtt_pkg::ADDR_CTL;
  assign wrEn    = busReq.wrEn && busReq.addr == dtt_pkg::ADDR_EN;
  assign wrFlag  = busReq.wrEn && busReq.addr == dtt_pkg::ADDR_FLAG;
  assign doClear = wrCtl && busReq.wrData[dtt_pkg::CTL_CLR_BIT];

  // Prescaler wraps once per 256 Hz period while running
  // TICK_DIV cycles per tick; the count restarts on the wrap edge
  assign tick = state_ff.runCtl && state_ff.preCnt == TICK_DIV - 1'b1;

  // Hold ends on the high read or when the window runs out
  // The least window is used so a slow reader still gets a fresh value
  assign release_ = state_ff.holdOn &&
    (rdHigh || state_ff.holdCnt == HOLD_CYC - 1'b1);

  // Visible eight-bit value; tap edges are taken from it
  assign cntAll = {state_ff.cntHigh, state_ff.cntLow};

  ////////////////////////////////////////////////////////////////
  // Tap selection and falling edge detection
  // Taps are the 32, 8, 2 and 1 Hz counter bits, in flag order
  for (genvar g = 0; g < dtt_pkg::TAP_N; g++)
  begin : gTap
    assign tapNow[g]  = cntAll[dtt_pkg::TAP_POS[g]];
    assign tapFall[g] = state_ff.tapPrev[g] && !tapNow[g];
  end

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    // One copy of the state is edited; each field defaults to holding
    nxt_state = state_ff;
    // Carry out of the low nibble, valid only on a tick
    carry     = 1'b0;

    // Prescaler runs only while counting; a stop keeps the phase
    if (state_ff.runCtl)
    begin
      if (tick)
        nxt_state.preCnt = '0;
      else
        nxt_state.preCnt = state_ff.preCnt + 1'b1;
    end

    // Low nibble counts freely, even during a hold
    if (tick)
    begin
      nxt_state.cntLow = state_ff.cntLow + dtt_pkg::NIB_ONE;
      carry = state_ff.cntLow == dtt_pkg::NIB_MAX;
    end

    // Only a low read arms the hold; a repeat read restarts it
    if (rdLow)
    begin
      nxt_state.holdOn  = 1'b1;
      nxt_state.holdCnt = '0;
    end
    else if (release_)
      nxt_state.holdOn = 1'b0;
    else if (state_ff.holdOn)
      nxt_state.holdCnt = state_ff.holdCnt + 1'b1;

    // A hold longer than one low-nibble period could defer two carries;
    // the least window is far shorter, so one pending bit suffices
    // High nibble takes carries unless frozen; a deferred carry
    // is added at release so no count is ever lost
    if (!state_ff.holdOn || release_)
    begin
      nxt_state.cntHigh = state_ff.cntHigh
        + {3'h0, carry} + {3'h0, state_ff.carryWait};
      nxt_state.carryWait = 1'b0;
    end
    else if (carry)
      nxt_state.carryWait = 1'b1;

    // Control write: run bit stored, clear acts once
    // The clear bit is not stored, so it always reads back as zero
    if (wrCtl)
      nxt_state.runCtl = busReq.wrData[dtt_pkg::CTL_RUN_BIT];

    // Clear zeroes the count; the run bit decides what follows
    // Clearing the prescaler makes the first tick a full period away
    if (doClear)
    begin
      nxt_state.cntLow    = '0;
      nxt_state.cntHigh   = '0;
      nxt_state.carryWait = 1'b0;
      nxt_state.preCnt    = '0;
    end

    // Forced zero is no tap edge, so the history is wiped
    if (doClear)
      nxt_state.tapPrev = '0;
    else
      nxt_state.tapPrev = tapNow;

    // Flags: a falling edge wins over a clear in the same cycle
    // Taps fall at most once per cycle, so no edge can be missed
    if (wrFlag)
      nxt_state.irqFlag = (state_ff.irqFlag & ~busReq.wrData)
        | tapFall;
    else
      nxt_state.irqFlag = state_ff.irqFlag | tapFall;

    // Enable register
    // Enables only gate the level; flags keep recording events
    if (wrEn)
      nxt_state.irqEnable = busReq.wrData;

    // Interrupt tracks the flag and enable flops in the same cycle
    // Using the next values saves a cycle of interrupt latency
    nxt_state.irq = |(nxt_state.irqFlag & nxt_state.irqEnable);

    // Read answer, valid only in the cycle after the strobe
    // Reads have no side effect except the hold arming and high read release above
    nxt_state.rdData = '0;
    if (busReq.rdEn)
    begin
      case (busReq.addr)
        dtt_pkg::ADDR_CTL:
          // Clear bit and upper bits read zero
          nxt_state.rdData[dtt_pkg::CTL_RUN_BIT] = state_ff.runCtl;
        dtt_pkg::ADDR_LOW:
          nxt_state.rdData = state_ff.cntLow;
        dtt_pkg::ADDR_HIGH:
          nxt_state.rdData = state_ff.cntHigh;
        dtt_pkg::ADDR_EN:
          nxt_state.rdData = state_ff.irqEnable;
        dtt_pkg::ADDR_FLAG:
          nxt_state.rdData = state_ff.irqFlag;
        // Unmapped addresses answer zero
        default:
          nxt_state.rdData = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register; reset zeroes counter, flags and enables
  // Reset is asynchronous; its release is left to the reset tree
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= dtt_pkg::STATE_RST;
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  // All checks share the clock and are off while reset is low;
  // they watch the state flops and decodes, and a failing label
  // names the rule that the logic broke
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Interrupt level matches the enabled flags every cycle
  chk_irq_level: assert property (
    tickIrq == |(state_ff.irqFlag & state_ff.irqEnable))
    else $error("interrupt level disagrees with flags");

  // Low read answers the low nibble one cycle later
  chk_low_read: assert property (
    rdLow |=> busRdData == $past(state_ff.cntLow))
    else $error("low nibble read data wrong");

  // Clear strobe zeroes the whole counter
  chk_clear_zero: assert property (
    doClear |=> cntAll == 8'h00)
    else $error("counter not zero after clear");

  // Stopped counter holds its value
  chk_stop_keep: assert property (
    !state_ff.runCtl && !wrCtl |=> $stable(cntAll))
    else $error("stopped counter changed");

  // 32 Hz tap edge sets its flag whatever the enables
  chk_flag_set: assert property (
    tapFall[0] |=> state_ff.irqFlag[0])
    else $error("32 Hz flag not set on falling edge");

  // Writing one clears the 8 Hz flag with no edge pending
  chk_flag_w1c: assert property (
    wrFlag && busReq.wrData[1] && !tapFall[1]
      |=> !state_ff.irqFlag[1])
    else $error("8 Hz flag not cleared by write");

  // Frozen high nibble does not move before release
  chk_hold_freeze: assert property (
    state_ff.holdOn && !release_ && !doClear |=> $stable(state_ff.cntHigh))
    else $error("high nibble moved during hold");

  // Hold never outlasts its window
  chk_hold_bound: assert property (
    state_ff.holdOn |-> state_ff.holdCnt < HOLD_CYC)
    else $error("hold window overran");

  // High read with no hold armed leaves the hold off
  chk_high_noarm: assert property (
    rdHigh && !state_ff.holdOn |=> !state_ff.holdOn)
    else $error("high read armed the hold");

  // Control read shows only the run bit
  chk_ctl_read: assert property (
    busReq.rdEn && busReq.addr == dtt_pkg::ADDR_CTL
      |=> busRdData == {3'h0, $past(state_ff.runCtl)})
    else $error("control read data wrong");

  // Running tick steps the low nibble by one
  chk_low_step: assert property (
    tick && !doClear |=> state_ff.cntLow == $past(state_ff.cntLow) + 4'h1)
    else $error("low nibble did not advance");

  // Read data fall back to zero after an idle cycle
  chk_rd_idle: assert property (
    !busReq.rdEn |=> busRdData == '0)
    else $error("read data not zero without a read");

  // High read answers the high nibble one cycle later
  chk_high_read: assert property (
    rdHigh |=> busRdData == $past(state_ff.cntHigh))
    else $error("high nibble read data wrong");

  // Low read arms a fresh hold window
  chk_low_arm: assert property (
    rdLow |=> state_ff.holdOn && state_ff.holdCnt == '0)
    else $error("low read did not arm the hold");

  // High read ends a running hold
  chk_high_release: assert property (
    rdHigh && state_ff.holdOn |=> !state_ff.holdOn)
    else $error("high read did not end the hold");

  // Hold ends by itself when the window runs out
  chk_hold_timeout: assert property (
    state_ff.holdOn && state_ff.holdCnt == HOLD_CYC - 1'b1 && !rdLow |=> !state_ff.holdOn)
    else $error("hold did not time out");

  // Deferred carry lands in the cycle the hold ends
  chk_defer_land: assert property (
    release_ && state_ff.carryWait && !carry && !doClear
      |=> state_ff.cntHigh == $past(state_ff.cntHigh) + dtt_pkg::NIB_ONE)
    else $error("deferred carry lost at release");

  // Unheld carry steps the high nibble at once
  chk_high_carry: assert property (
    carry && !state_ff.holdOn && !doClear
      |=> state_ff.cntHigh == $past(state_ff.cntHigh) + dtt_pkg::NIB_ONE)
    else $error("high nibble missed a carry");

  // Writes to the count nibbles leave the counter alone
  chk_count_ro: assert property (
    busReq.wrEn && !tick && !state_ff.holdOn &&
      (busReq.addr == dtt_pkg::ADDR_LOW || busReq.addr == dtt_pkg::ADDR_HIGH)
      |=> $stable(cntAll))
    else $error("count nibble took a write");

  // Run bit follows the written value
  chk_run_write: assert property (
    wrCtl |=> state_ff.runCtl == $past(busReq.wrData[dtt_pkg::CTL_RUN_BIT]))
    else $error("run bit not stored");

  // Stopped prescaler keeps its phase
  chk_stop_phase: assert property (
    !state_ff.runCtl && !doClear |=> $stable(state_ff.preCnt))
    else $error("prescaler moved while stopped");

  // Enable write stores the nibble
  chk_en_write: assert property (
    wrEn |=> state_ff.irqEnable == $past(busReq.wrData))
    else $error("enable register not stored");

  // Flags only drop through a flag write
  chk_flag_sticky: assert property (
    !wrFlag |=> (state_ff.irqFlag & $past(state_ff.irqFlag)) == $past(state_ff.irqFlag))
    else $error("flag dropped without a write");

  // Masked taps never raise the interrupt
  chk_irq_masked: assert property (
    state_ff.irqEnable == '0 |-> !tickIrq)
    else $error("interrupt raised while all masked");

  // Each tap edge sets its own flag
  for (genvar c = 0; c < dtt_pkg::TAP_N; c++)
  begin : gTapChk
    chk_tap_flag: assert property (
      @(posedge ref_clk) disable iff (!rst_n) tapFall[c] |=> state_ff.irqFlag[c])
      else $error("tap flag not set on falling edge");
  end

  // Scenarios worth seeing
  // Covers show that the bench reaches each main scenario
  cov_hold_read: cover property (
    rdLow ##[1:20] rdHigh);
  cov_hold_timeout: cover property (
    state_ff.holdOn && !rdHigh && release_);
  cov_irq_raise: cover property (
    !tickIrq ##1 tickIrq);
  cov_deferred: cover property (
    state_ff.carryWait ##1 !state_ff.carryWait);
  cov_count_wrap: cover property (
    cntAll == 8'hFF ##1 cntAll == 8'h00);

endmodule : dtt_tick_timer

// ==== dtt_testbench.sv ====
`timescale 1ns/1ps
module testbench;
  //////////////////////////////////////////////////////////////////
  // Short counts keep the run brief; expectations derive from them
  localparam int unsigned TDIV = 4;
  localparam int unsigned HCYC = 8;

  logic                  ref_clk;         // Bench clock
  logic                  rst_n;           // Reset, active low
  dtt_pkg::dtt_bus_req_s busReq;          // Register request
  dtt_pkg::dtt_nib_t     busRdData;       // Read answer
  logic                  tickIrq;         // Interrupt level
  dtt_pkg::dtt_nib_t     lo;              // Low nibble seen
  dtt_pkg::dtt_nib_t     hi;              // High nibble seen
  dtt_pkg::dtt_nib_t     rv;              // Random nibble
  logic [7:0]            cnt;             // Counter value seen
  logic [31:0]           rndState;        // Random source
  int                    errCount;        // Mismatches
  int                    samplesChecked;  // Comparisons
  int                    cycleCount;      // Timeout count

  dtt_tick_timer #(
    .TICK_DIV(dtt_pkg::dtt_pre_t'(TDIV)),
    .HOLD_CYC(dtt_pkg::dtt_hold_t'(HCYC))
  ) dut (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .busReq   (busReq),
    .busRdData(busRdData),
    .tickIrq  (tickIrq)
  );

  //////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Run needs about 1500 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk)
  begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000)
    begin
      errCount++;
      endOfTest();
    end
  end

  //////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Interrupt level expected from flags and enables
  function automatic logic expIrq(input logic [3:0] f, input logic [3:0] e);
    return |(f & e);
  endfunction : expIrq

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt

  // One write cycle, then one idle edge so strobes never collide
  task automatic wr(input dtt_pkg::dtt_addr_t a, input dtt_pkg::dtt_nib_t d);
    busReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge ref_clk);
    busReq <= '{addr: a, wrData: d, wrEn: 1'b0, rdEn: 1'b0};
    @(posedge ref_clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input dtt_pkg::dtt_addr_t a, output dtt_pkg::dtt_nib_t v);
    busReq <= '{addr: a, wrData: 4'h0, wrEn: 1'b0, rdEn: 1'b1};
    @(posedge ref_clk);
    busReq <= '{addr: a, wrData: 4'h0, wrEn: 1'b0, rdEn: 1'b0};
    #1 v = busRdData;
    @(posedge ref_clk);
  endtask : rd

  task automatic rdChk(input dtt_pkg::dtt_addr_t a, input dtt_pkg::dtt_nib_t e);
    dtt_pkg::dtt_nib_t v;
    rd(a, v);
    check({4'h0, v}, {4'h0, e});
  endtask : rdChk

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : endOfTest

  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    busReq = '0;
    rst_n = 1'b0;
    rndState = 32'h2CDD;
    errCount = 0;
    samplesChecked = 0;
    cycleCount = 0;
    wt(8);
    rst_n <= 1'b1;
    wt(1);
    // Reset values, unmapped read, stopped counter
    rdChk(dtt_pkg::ADDR_CTL, 4'h0);
    rdChk(dtt_pkg::ADDR_LOW, 4'h0);
    rdChk(dtt_pkg::ADDR_HIGH, 4'h0);
    rdChk(dtt_pkg::ADDR_EN, 4'h0);
    rdChk(dtt_pkg::ADDR_FLAG, 4'h0);
    rdChk(16'h1234, 4'h0);
    check({7'h00, tickIrq}, 8'h00);
    wt(40);
    rdChk(dtt_pkg::ADDR_LOW, 4'h0);
    $display("test reset done");
    // Count, stop, hold value, resume from it
    wr(dtt_pkg::ADDR_CTL, 4'h3);
    rdChk(dtt_pkg::ADDR_CTL, 4'h1);
    wt(35);
    wr(dtt_pkg::ADDR_CTL, 4'h0);
    rd(dtt_pkg::ADDR_LOW, lo);
    rd(dtt_pkg::ADDR_HIGH, hi);
    cnt = {hi, lo};
    check({7'h00, cnt >= 8'h09 && cnt <= 8'h0B}, 8'h01);
    wt(20);
    rdChk(dtt_pkg::ADDR_LOW, lo);
    wr(dtt_pkg::ADDR_CTL, 4'h1);
    wt(18);
    wr(dtt_pkg::ADDR_CTL, 4'h0);
    rd(dtt_pkg::ADDR_LOW, lo);
    rd(dtt_pkg::ADDR_HIGH, hi);
    check({7'h00, {hi, lo} >= cnt + 8'h04 && {hi, lo} <= cnt + 8'h07}, 8'h01);
    $display("test run stop done");
    // Writes to the count nibbles are ignored; clear while stopped
    cnt = {hi, lo};
    repeat (3)
    begin
      rndState = lfsr(rndState);
      rv = rndState[3:0];
      wr(dtt_pkg::ADDR_LOW, rv);
      wr(dtt_pkg::ADDR_HIGH, ~rv);
      rdChk(dtt_pkg::ADDR_LOW, cnt[3:0]);
      rdChk(dtt_pkg::ADDR_HIGH, cnt[7:4]);
    end
    wr(dtt_pkg::ADDR_CTL, 4'h2);
    rdChk(dtt_pkg::ADDR_CTL, 4'h0);
    wt(20);
    rdChk(dtt_pkg::ADDR_LOW, 4'h0);
    rdChk(dtt_pkg::ADDR_HIGH, 4'h0);
    $display("test clear done");
    // Carry from 0F comes while the high nibble is held and lands at the high read release
    wr(dtt_pkg::ADDR_CTL, 4'h3);
    wt(60);
    rdChk(dtt_pkg::ADDR_LOW, 4'hF);
    wt(4);
    rdChk(dtt_pkg::ADDR_HIGH, 4'h0);
    rdChk(dtt_pkg::ADDR_HIGH, 4'h1);
    wr(dtt_pkg::ADDR_CTL, 4'h0);
    $display("test hold done");
    // Flags set while masked; enables gate the level only
    wr(dtt_pkg::ADDR_FLAG, 4'hF);
    wr(dtt_pkg::ADDR_CTL, 4'h3);
    wt(35);
    wr(dtt_pkg::ADDR_CTL, 4'h0);
    rdChk(dtt_pkg::ADDR_FLAG, 4'h1);
    check({7'h00, tickIrq}, 8'h00);
    wr(dtt_pkg::ADDR_FLAG, 4'h0);
    rdChk(dtt_pkg::ADDR_FLAG, 4'h1);
    repeat (4)
    begin
      rndState = lfsr(rndState);
      rv = rndState[3:0];
      wr(dtt_pkg::ADDR_EN, rv);
      rdChk(dtt_pkg::ADDR_EN, rv);
      check({7'h00, tickIrq}, {7'h00, expIrq(4'h1, rv)});
    end
    wr(dtt_pkg::ADDR_EN, 4'h1);
    check({7'h00, tickIrq}, 8'h01);
    wr(dtt_pkg::ADDR_FLAG, 4'h1);
    rdChk(dtt_pkg::ADDR_FLAG, 4'h0);
    check({7'h00, tickIrq}, 8'h00);
    // Every tap falls once the counter passes 256
    wr(dtt_pkg::ADDR_EN, 4'h8);
    wr(dtt_pkg::ADDR_CTL, 4'h3);
    wt(1100);
    wr(dtt_pkg::ADDR_CTL, 4'h0);
    rdChk(dtt_pkg::ADDR_FLAG, 4'hF);
    check({7'h00, tickIrq}, 8'h01);
    $display("test interrupt done");
    endOfTest();
  end
endmodule : testbench
